/* hw/cwr_codec_control_word_writer.sv */
// serial control port of the codec: receives two-byte control words and holds the control registers
`timescale 1ns/1ps

// Overview of operation
// [RULE1] address top seven bits, field nine lsb
// [RULE2] master sends start, address, data, stop
// [RULE3] exactly two data bytes per transaction
// [RULE4] answer only at slave address 0x1A
// [RULE5] all ones enters reset, zeros leave
// [RULE6] power down bit nine stored zero
// [RULE7] format register selects audio port mode
// [RULE8] sample rate register holds rate code
// [RULE9] activation bit makes audio interface active
// [RULE10] analog path register holds path selections
// [RULE11] digital path register holds filter settings
// [RULE12] line volume ninth bit writes both channels
// [RULE13] headphone ninth bit writes both channels
// [RULE14] lowest headphone volume silences output
// [RULE15] respond only when direction bit zero
// [RULE16] acknowledge by pulling data low, ninth clock
// [RULE17] fixed addresses of the eleven registers
// [RULE18] commit only after both bytes acknowledged
// [RULE19] master writes reset, power, then rest
module cwr_codec_control_word_writer #(
  parameter logic [cwr_pkg::HP_VOL_W-1:0] hp_silence_code = 7'h00
) (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // serial control link
  input wire logic scl_i,
  input wire logic control_serial_data_line_i,
  output logic control_serial_data_line_o,
  output logic control_serial_data_line_oe_b_o,
  // control register contents
  output logic [cwr_pkg::DATA_W-1:0] left_line_in_volume_o,
  output logic [cwr_pkg::DATA_W-1:0] right_line_in_volume_o,
  output logic [cwr_pkg::DATA_W-1:0] left_headphone_volume_o,
  output logic [cwr_pkg::DATA_W-1:0] right_headphone_volume_o,
  output logic [cwr_pkg::DATA_W-1:0] analog_path_control_o,
  output logic [cwr_pkg::DATA_W-1:0] digital_path_control_o,
  output logic [cwr_pkg::DATA_W-1:0] power_down_control_o,
  output logic [cwr_pkg::DATA_W-1:0] audio_interface_format_o,
  output logic [cwr_pkg::DATA_W-1:0] sample_rate_control_o,
  output logic [cwr_pkg::DATA_W-1:0] interface_activation_o,
  // decoded device state
  output logic device_in_reset_o,
  output logic audio_interface_active_o,
  output logic headphone_silent_o
);
  import cwr_pkg::*;

  // link domain, clocked by the serial clock
  // each rising edge captures one data bit and flips an event toggle; the bit
  // stays put for a whole serial clock period, far longer than the core needs
  // only the toggle is synchronised: the core reads the captured bit after the
  // toggle has crossed, by which time the bit has long settled, so the bit
  // needs no gray code and no second handshake
  logic link_bit_q, link_bit_d;
  logic link_tog_q, link_tog_d;

  always_comb begin
    link_bit_d = control_serial_data_line_i;
    link_tog_d = ~link_tog_q;
  end

  always_ff @(posedge scl_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_bit_q <= 1'b0;
      link_tog_q <= 1'b0;
    end else begin
      link_bit_q <= link_bit_d;
      link_tog_q <= link_tog_d;
    end
  end

  // core domain synchronisers
  // both wires and the toggle pass two flops; the wires reset to their idle
  // high level, so releasing reset cannot fake a start or a stop
  logic scl_meta_q, scl_sync_q, scl_prev_q;
  logic sda_meta_q, sda_sync_q, sda_prev_q;
  logic tog_meta_q, tog_sync_q, tog_prev_q;
  logic [2:0] sync_d;
  logic [2:0] prev_d;

  always_comb begin
    sync_d = {scl_meta_q, sda_meta_q, tog_meta_q};
    prev_d = {scl_sync_q, sda_sync_q, tog_sync_q};
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_prev_q <= 1'b1;
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_prev_q <= 1'b0;
    end else begin
      scl_meta_q <= scl_i;
      sda_meta_q <= control_serial_data_line_i;
      tog_meta_q <= link_tog_q;
      {scl_sync_q, sda_sync_q, tog_sync_q} <= sync_d;
      {scl_prev_q, sda_prev_q, tog_prev_q} <= prev_d;
    end
  end

  logic start_seen;
  logic stop_seen;
  logic scl_fall;
  logic bit_event;

  // limitation: each serial clock phase must last four core cycles or more,
  // otherwise starts, stops and clock edges slip past the synchronisers
  // [RULE2] frame start and stop
  always_comb begin
    start_seen = scl_sync_q && scl_prev_q && sda_prev_q && !sda_sync_q;
    stop_seen = scl_sync_q && scl_prev_q && !sda_prev_q && sda_sync_q;
    scl_fall = scl_prev_q && !scl_sync_q;
    bit_event = tog_sync_q ^ tog_prev_q;
  end

  // byte receiver and acknowledge
  // bit_cnt rests at eight through the acknowledge clock
  cwr_state_t state_q, state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [1:0] byte_idx_q, byte_idx_d;
  logic [BYTE_W-1:0] shift_q, shift_d;
  logic [BYTE_W-1:0] first_q, first_d;
  logic drive_b_q, drive_b_d;
  logic commit;
  logic [BYTE_W-1:0] shift_next;

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    byte_idx_d = byte_idx_q;
    shift_d = shift_q;
    first_d = first_q;
    drive_b_d = drive_b_q;
    commit = 1'b0;
    shift_next = {shift_q[BYTE_W-2:0], link_bit_q};
    if (start_seen) begin
      // a repeated start abandons any half-received word
      state_d = CWR_RECV;
      bit_cnt_d = 4'h0;
      byte_idx_d = BYTE_SLAVE;
      drive_b_d = 1'b1;
    end else if (stop_seen) begin
      // a stop before the second acknowledge drops the half-received word
      state_d = CWR_IDLE;
      drive_b_d = 1'b1;
    end else begin
      case (state_q)
        CWR_IDLE: begin
          drive_b_d = 1'b1;
        end
        CWR_RECV: begin
          if (bit_event) begin
            shift_d = shift_next;
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q + 4'h1 == BITS_PER_BYTE) begin
              if (byte_idx_q == BYTE_SLAVE) begin
                // [RULE4] match own address
                // [RULE15] writes only
                if (shift_next[BYTE_W-1:1] == SLAVE_ADDR && shift_next[0] == DIR_WRITE) begin
                  state_d = CWR_ACK_WAIT;
                end else begin
                  state_d = CWR_IGNORE;
                end
              end else begin
                if (byte_idx_q == BYTE_FIRST) begin
                  first_d = shift_next;
                end
                state_d = CWR_ACK_WAIT;
              end
            end
          end
        end
        CWR_ACK_WAIT: begin
          // the pin moves only while the serial clock is low, so our own
          // acknowledge can never look like a start or a stop
          // [RULE16] pull data low for the ninth clock
          if (scl_fall) begin
            drive_b_d = 1'b0;
            state_d = CWR_ACK_DRIVE;
          end
        end
        CWR_ACK_DRIVE: begin
          // the ninth rising edge is our own acknowledge; its bit event is dropped
          if (scl_fall) begin
            drive_b_d = 1'b1;
            bit_cnt_d = 4'h0;
            if (byte_idx_q == BYTE_SECOND) begin
              // committing here rather than at the stop keeps words that are
              // chained by a repeated start from being lost
              // [RULE18] commit after second acknowledge
              commit = 1'b1;
              // [RULE3] further bytes are not acknowledged
              state_d = CWR_IGNORE;
            end else begin
              byte_idx_d = byte_idx_q + 2'h1;
              state_d = CWR_RECV;
            end
          end
        end
        CWR_IGNORE: begin
          // silent until the next start, whatever the master sends
          drive_b_d = 1'b1;
        end
        default: begin
          state_d = CWR_IDLE;
          drive_b_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= CWR_IDLE;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= BYTE_SLAVE;
      shift_q <= 8'h00;
      first_q <= 8'h00;
      drive_b_q <= 1'b1;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      byte_idx_q <= byte_idx_d;
      shift_q <= shift_d;
      first_q <= first_d;
      drive_b_q <= drive_b_d;
    end
  end

  // open drain: the pin is only ever pulled low, never driven high
  assign control_serial_data_line_o = 1'b0;
  assign control_serial_data_line_oe_b_o = drive_b_q;

  // control registers
  // a cut frame never raises commit, so every register keeps its old word
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] ctl_q [int'(CTRL_COUNT)];
  logic [DATA_W-1:0] ctl_d [int'(CTRL_COUNT)];
  logic soft_reset_q, soft_reset_d;
  logic silent_q, silent_d;
  logic hp_left_floor, hp_right_floor;

  // [RULE1] split the word into address and fields
  always_comb begin
    wr_addr = first_q[BYTE_W-1:1];
    wr_data = {first_q[0], shift_q};
  end

  // at most one register changes per word, two for a paired volume write
  always_comb begin
    ctl_d = ctl_q;
    soft_reset_d = soft_reset_q;
    if (commit) begin
      // [RULE17] address decode
      case (wr_addr)
        // with the pair bit clear only the addressed channel is written
        // [RULE12] line volume pair update
        REG_LINE_L, REG_LINE_R: begin
          ctl_d[wr_addr[3:0]] = wr_data;
          if (wr_data[SIMUL_BIT]) begin
            ctl_d[REG_LINE_L[3:0]] = wr_data;
            ctl_d[REG_LINE_R[3:0]] = wr_data;
          end
        end
        // [RULE13] headphone pair update
        REG_HP_L, REG_HP_R: begin
          ctl_d[wr_addr[3:0]] = wr_data;
          if (wr_data[SIMUL_BIT]) begin
            ctl_d[REG_HP_L[3:0]] = wr_data;
            ctl_d[REG_HP_R[3:0]] = wr_data;
          end
        end
        // [RULE6] reserved top field kept zero
        REG_POWER: begin
          ctl_d[REG_POWER[3:0]] = wr_data & POWER_WR_MASK;
        end
        // any other word leaves the reset state as it was
        // [RULE5] enter or leave reset
        REG_RESET: begin
          if (wr_data == RESET_ENTER) begin
            soft_reset_d = 1'b1;
          end else if (wr_data == RESET_LEAVE) begin
            soft_reset_d = 1'b0;
          end
        end
        // [RULE7] [RULE8] [RULE9] [RULE10] [RULE11] plain stores
        default: begin
          // unmapped addresses are acknowledged but change nothing
          if (wr_addr < CTRL_COUNT) begin
            ctl_d[wr_addr[3:0]] = wr_data;
          end
        end
      endcase
    end
  end

  // [RULE14] both headphone channels at the floor
  // the next values are compared so the flag moves on the same edge as the
  // volumes and never shows a stale decode after a write
  always_comb begin
    hp_left_floor = ctl_d[REG_HP_L[3:0]][HP_VOL_W-1:0] <= hp_silence_code;
    hp_right_floor = ctl_d[REG_HP_R[3:0]][HP_VOL_W-1:0] <= hp_silence_code;
    silent_d = hp_left_floor && hp_right_floor;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < int'(CTRL_COUNT); i++) begin
        ctl_q[i] <= CTRL_RESET_VALUE;
      end
      soft_reset_q <= SOFT_RESET_INIT;
      silent_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      soft_reset_q <= soft_reset_d;
      silent_q <= silent_d;
    end
  end

  assign left_line_in_volume_o = ctl_q[REG_LINE_L[3:0]];
  assign right_line_in_volume_o = ctl_q[REG_LINE_R[3:0]];
  assign left_headphone_volume_o = ctl_q[REG_HP_L[3:0]];
  assign right_headphone_volume_o = ctl_q[REG_HP_R[3:0]];
  assign analog_path_control_o = ctl_q[REG_ANALOG[3:0]];
  assign digital_path_control_o = ctl_q[REG_DIGITAL[3:0]];
  assign power_down_control_o = ctl_q[REG_POWER[3:0]];
  assign audio_interface_format_o = ctl_q[REG_FORMAT[3:0]];
  assign sample_rate_control_o = ctl_q[REG_RATE[3:0]];
  assign interface_activation_o = ctl_q[REG_ACTIVE[3:0]];
  // the reset state is only reported; the control registers keep their words
  assign device_in_reset_o = soft_reset_q;
  // [RULE9] audio port active flag
  assign audio_interface_active_o = ctl_q[REG_ACTIVE[3:0]][ACTIVE_BIT];
  assign headphone_silent_o = silent_q;

endmodule

/* hw/cwr_pkg.sv */
// constants and types shared by the codec control word writer
package cwr_pkg;

  // control word layout
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SIMUL_BIT = 8;
  localparam int HP_VOL_W = 7;

  // bus slave address, write direction code
  localparam logic [ADDR_W-1:0] SLAVE_ADDR = 7'h1a;
  localparam logic DIR_WRITE = 1'h0;

  // byte positions inside one transaction
  localparam logic [1:0] BYTE_SLAVE = 2'h0;
  localparam logic [1:0] BYTE_FIRST = 2'h1;
  localparam logic [1:0] BYTE_SECOND = 2'h2;

  // control register addresses
  localparam logic [ADDR_W-1:0] REG_LINE_L = 7'h00;
  localparam logic [ADDR_W-1:0] REG_LINE_R = 7'h01;
  localparam logic [ADDR_W-1:0] REG_HP_L = 7'h02;
  localparam logic [ADDR_W-1:0] REG_HP_R = 7'h03;
  localparam logic [ADDR_W-1:0] REG_ANALOG = 7'h04;
  localparam logic [ADDR_W-1:0] REG_DIGITAL = 7'h05;
  localparam logic [ADDR_W-1:0] REG_POWER = 7'h06;
  localparam logic [ADDR_W-1:0] REG_FORMAT = 7'h07;
  localparam logic [ADDR_W-1:0] REG_RATE = 7'h08;
  localparam logic [ADDR_W-1:0] REG_ACTIVE = 7'h09;
  localparam logic [ADDR_W-1:0] REG_RESET = 7'h0f;
  localparam logic [ADDR_W-1:0] CTRL_COUNT = 7'h0a;

  // field values and masks
  localparam logic [DATA_W-1:0] RESET_ENTER = 9'h1ff;
  localparam logic [DATA_W-1:0] RESET_LEAVE = 9'h000;
  localparam logic [DATA_W-1:0] POWER_WR_MASK = 9'h0ff;
  localparam int ACTIVE_BIT = 0;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RESET_VALUE = 9'h000;
  localparam logic SOFT_RESET_INIT = 1'h0;

  typedef enum logic [2:0] {
    CWR_IDLE,
    CWR_RECV,
    CWR_ACK_WAIT,
    CWR_ACK_DRIVE,
    CWR_IGNORE
  } cwr_state_t;

endpackage

/* testbench/cwr_checker.sv */
// port checks for the codec control word writer
`timescale 1ns/1ps
module cwr_checker
  import cwr_pkg::*;
#(
  parameter logic [cwr_pkg::HP_VOL_W-1:0] hp_silence_code = 7'h00
) (
  // clock, reset and ack enable
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic control_serial_data_line_oe_b_o,
  // register contents
  input wire logic [cwr_pkg::DATA_W-1:0] left_line_in_volume_o,
  input wire logic [cwr_pkg::DATA_W-1:0] right_line_in_volume_o,
  input wire logic [cwr_pkg::DATA_W-1:0] left_headphone_volume_o,
  input wire logic [cwr_pkg::DATA_W-1:0] right_headphone_volume_o,
  input wire logic [cwr_pkg::DATA_W-1:0] power_down_control_o,
  input wire logic [cwr_pkg::DATA_W-1:0] interface_activation_o,
  // decodes
  input wire logic audio_interface_active_o,
  input wire logic headphone_silent_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic ob;
  logic [DATA_W-1:0] ll, rl, lh, rh;
  assign ob = control_serial_data_line_oe_b_o;
  assign ll = left_line_in_volume_o;
  assign rl = right_line_in_volume_o;
  assign lh = left_headphone_volume_o;
  assign rh = right_headphone_volume_o;
  a_ack_holds: assert property ($fell(ob) |-> !ob [*6])
    else $error("ack released too early");
  a_ack_bounded: assert property ($fell(ob) |-> ##[6:40] ob)
    else $error("ack held too long");
  // only the release of the last ack may commit
  a_commit_at_ack: assert property ($changed({ll, rl, lh, rh, power_down_control_o}) |-> $rose(ob))
    else $error("register changed outside commit");
  a_power_bit_zero: assert property (power_down_control_o[8] == 1'b0)
    else $error("power bit nine set");
  a_active_bit: assert property (audio_interface_active_o == interface_activation_o[0])
    else $error("active decode mismatch");
  a_line_pair: assert property ($changed(ll) && $changed(rl) |-> ll == rl)
    else $error("line pair differs");
  a_hp_pair: assert property ($changed(lh) && $changed(rh) |-> lh == rh)
    else $error("headphone pair differs");
  a_silence_decode: assert property ($past(rst_b_i) |->
    headphone_silent_o == (lh[6:0] <= hp_silence_code && rh[6:0] <= hp_silence_code))
    else $error("silence decode mismatch");
endmodule

bind cwr_codec_control_word_writer cwr_checker #(.hp_silence_code(hp_silence_code)) u_chk (
  .core_clk_i, .rst_b_i, .control_serial_data_line_oe_b_o, .left_line_in_volume_o,
  .right_line_in_volume_o, .left_headphone_volume_o, .right_headphone_volume_o,
  .power_down_control_o, .interface_activation_o, .audio_interface_active_o, .headphone_silent_o
);

/* testbench/cwr_i2c_master.sv */
// bus master model driving the control link
`timescale 1ns/1ps
module cwr_i2c_master (
  // link wires
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // 120 ns phases, two 60 ns link ticks, so the core sync keeps up
  localparam int Q = 60;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic put(input logic b, output logic ack);
    sda_low_o = ~b;
    #Q scl_o = 1'b1;
    #Q ack = ~sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  // msb first, ninth clock released for ack
  task automatic tx_byte(input logic [7:0] v, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) put(v[i], d);
    put(1'b1, ack);
  endtask
  // start, address, n data bytes, stop
  task automatic xfer(input logic [7:0] a, b1, b2, input int n, output logic [3:0] acks);
    logic [7:0] v [3];
    logic k;
    v = '{b1, b2, b1};
    acks = 4'h0;
    sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q tx_byte(a, k);
    acks[0] = k;
    for (int i = 0; i < n; i++) begin
      tx_byte(v[i], k);
      acks[i+1] = k;
    end
    sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    // clock stands high between frames
    #(4*Q);
  endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the codec control word writer
`timescale 1ns/1ps
module testbench;
  import cwr_pkg::*;
  localparam logic [6:0] HPC = 7'h00;
  localparam logic [15:0] CFG [10] = '{16'h0c07, 16'h0810, 16'h0a01, 16'h0e43, 16'h1022,
    16'h1201, 16'h0117, 16'h0317, 16'h05ff, 16'h07ff};
  logic clk, rst_b, scl, sda_low, sda, sda_o, oe_b, dev_rst, active, silent, ex_rst;
  logic [DATA_W-1:0] q [10];
  logic [DATA_W-1:0] ex [10];
  int error_cnt, n_tests;
  cwr_codec_control_word_writer #(.hp_silence_code(HPC)) uut (
    .core_clk_i(clk),
    .rst_b_i(rst_b),
    .scl_i(scl),
    .control_serial_data_line_i(sda),
    .control_serial_data_line_o(sda_o),
    .control_serial_data_line_oe_b_o(oe_b),
    .left_line_in_volume_o(q[0]),
    .right_line_in_volume_o(q[1]),
    .left_headphone_volume_o(q[2]),
    .right_headphone_volume_o(q[3]),
    .analog_path_control_o(q[4]),
    .digital_path_control_o(q[5]),
    .power_down_control_o(q[6]),
    .audio_interface_format_o(q[7]),
    .sample_rate_control_o(q[8]),
    .interface_activation_o(q[9]),
    .device_in_reset_o(dev_rst),
    .audio_interface_active_o(active),
    .headphone_silent_o(silent)
  );
  cwr_i2c_master m (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
  // open drain wire with pull-up
  assign sda = sda_low ? 1'b0 : (!oe_b ? sda_o : 1'b1);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic sil(input logic [8:0] l, r);
    return l[6:0] <= HPC && r[6:0] <= HPC;
  endfunction
  task automatic chk_regs();
    for (int i = 0; i < 10; i++) chk($sformatf("reg%0d", i), ex[i], q[i]);
    chk("in_reset", {8'h0, ex_rst}, {8'h0, dev_rst});
    chk("active", {8'h0, ex[9][0]}, {8'h0, active});
    chk("silent", {8'h0, sil(ex[2], ex[3])}, {8'h0, silent});
  endtask
  task automatic upd(input logic [7:0] b1, b2);
    logic [6:0] ra;
    logic [8:0] d;
    ra = b1[7:1];
    d = {b1[0], b2};
    if (ra < 7'h04 && d[8]) begin
      ex[ra & 7'h7e] = d;
      ex[ra | 7'h01] = d;
    end else if (ra < 7'h0a) ex[ra] = (ra == 7'h06) ? {1'b0, d[7:0]} : d;
    else if (ra == 7'h0f && d == 9'h1ff) ex_rst = 1'b1;
    else if (ra == 7'h0f && d == 9'h000) ex_rst = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, b1, b2, input int n);
    logic [3:0] acks;
    logic ok;
    m.xfer(a, b1, b2, n, acks);
    ok = (a == 8'h34);
    chk("acks", {5'h0, 1'b0, ok && n > 1, ok && n > 0, ok}, {5'h0, acks});
    if (ok && n > 1) upd(b1, b2);
    repeat (4) @(negedge clk);
    chk_regs();
  endtask
  initial begin
    #2_000_000;
    error_cnt++;
    results();
  end
  initial begin
    logic [6:0] ra;
    rst_b = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    ex = '{default: 9'h000};
    ex_rst = 1'b0;
    void'($urandom(32'h8300d4cb));
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    chk_regs();
    wr(8'h34, 8'h1f, 8'hff, 2);
    wr(8'h34, 8'h1e, 8'h00, 2);
    wr(8'h34, 8'h0d, 8'hff, 2);
    foreach (CFG[i]) wr(8'h34, CFG[i][15:8], CFG[i][7:0], 2);
    wr(8'h34, 8'h00, 8'h05, 2);
    wr(8'h34, 8'h04, 8'h00, 2);
    wr(8'h34, 8'h06, 8'h00, 2);
    wr(8'h34, 8'h06, 8'h01, 2);
    wr(8'h36, 8'h00, 8'h55, 2);
    wr(8'h35, 8'h00, 8'h55, 2);
    wr(8'h34, 8'h0c, 8'h3c, 1);
    wr(8'h34, 8'h0e, 8'h11, 3);
    wr(8'h34, 8'h14, 8'h77, 2);
    wr(8'h34, 8'h1e, 8'h05, 2);
    repeat (20) begin
      ra = 7'($urandom_range(9));
      wr(8'h34, {ra, 1'($urandom)}, 8'($urandom), 2);
    end
    // reset in mid-run clears everything again
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    ex = '{default: 9'h000};
    ex_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_regs();
    results();
  end
endmodule
